// file: verilog/fmt_pkg.sv
/*
 * Constants for the track-format and forced-interrupt command engine.
 * Assumes a single 125 MHz clock domain and an Avalon-MM register port.
 */
package fmt_pkg;
    // Register word addresses (byte address = 4 * index)
    localparam logic [1:0] ADDR_CMD_STATUS = 2'h0;
    localparam logic [1:0] ADDR_BYTE_BUF = 2'h1;
    localparam logic [1:0] ADDR_CTRL = 2'h2;
    localparam logic [1:0] ADDR_TRACK_OUT = 2'h3;
    // Status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_BYTE_REQ = 1;
    localparam int ST_LOST = 2;
    localparam int ST_INDEX = 1;
    localparam int ST_READY_N = 7;
    // Command codes
    localparam logic [3:0] CMD_TYPE_FORCE = 4'hD;
    localparam logic [3:0] CMD_TYPE_WRTRK = 4'hF;
    // Control byte codes
    localparam logic [7:0] CODE_LO = 8'hF5;
    localparam logic [7:0] CODE_HI = 8'hFE;
    localparam logic [7:0] CODE_A1 = 8'hF5;
    localparam logic [7:0] CODE_C2 = 8'hF6;
    localparam logic [7:0] CODE_CRC = 8'hF7;
    localparam logic [7:0] CODE_FC = 8'hFC;
    localparam logic [7:0] CODE_FD = 8'hFD;
    localparam logic [7:0] CODE_F8 = 8'hF8;
    localparam logic [7:0] MFM_A1 = 8'hA1;
    localparam logic [7:0] MFM_C2 = 8'hC2;
    localparam logic [7:0] CLK_NORMAL = 8'hFF;
    localparam logic [7:0] CLK_MARK_C7 = 8'hC7;
    localparam logic [7:0] CLK_MARK_D7 = 8'hD7;
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    // Byte cell time: 64 us FM, 32 us MFM
    localparam int CLK_MHZ = 125;
    localparam int CELL_FM_US = 64;
    localparam int CELL_MFM_US = 32;
    localparam logic [13:0] CELL_FM_CYC = 14'(CELL_FM_US * CLK_MHZ);
    localparam logic [13:0] CELL_MFM_CYC = 14'(CELL_MFM_US * CLK_MHZ);
    localparam logic [7:0] STATUS_RESET = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_IDX = 2'b01,
        ST_WRITE = 2'b11
    } eng_e;
endpackage

// file: verilog/fmt_engine.sv
/*
 * Track-format write and forced-interrupt command engine with status,
 * byte-request and interrupt handling, behind an Avalon-MM slave.
 * Assumes index and ready inputs synchronous to sys_clk.
 */
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Track write command loads head and sets busy before writing.
// - Write from first index leading edge to next index, then interrupt.
// - Byte request raised at command; writing waits for first buffer load.
// - Buffer empty at start index: abort, clear busy, lost data, interrupt.
// - Missing byte during writing is replaced by zero, writing continues.
// - Normal bytes use normal clock; F5..FE are mark or CRC codes.
// - CRC preset on F8..FB and FE in FM, or on F5 in MFM.
// - F7 emits the two CRC bytes in either density.
// - FM clocks: FF normal, C7 with preset for F8..FB/FE, D7 for FC.
// - MFM F5 writes A1 missing clock, preset; F6 writes C2.
// - Forced interrupt accepted anytime; terminates command, clears busy.
// - Low four command bits enable OR-ed interrupt conditions.
// - Any enabled condition drives interrupt output high.
// - Condition bits zero terminate immediately with no interrupt.
// - Immediate interrupt sticks until a D0 command is issued.
// - Other commands set busy; forced interrupt while busy clears busy only.
// - Buffer read or write clears byte-request bit and line.
// - Status read clears interrupt except pending immediate interrupt.
module fmt_engine
    import fmt_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Drive side
    input wire logic index_pulse,
    input wire logic drive_ready,
    output logic head_load,
    output logic write_gate,
    output logic [7:0] wr_data,
    output logic [7:0] wr_clock,
    output logic wr_strobe,
    // Host lines
    output logic byte_request,
    output logic completion_irq
);

    // ==========================================
    // Decode helpers
    function automatic logic is_code(input logic [7:0] b);
        is_code = (b >= CODE_LO) && (b <= CODE_HI);
    endfunction

    function automatic logic fm_preset(input logic [7:0] b);
        fm_preset = ((b >= CODE_F8) && (b <= CODE_HI) && (b != CODE_FC) && (b != CODE_FD));
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c;
        for (int i = 7; i >= 0; i--) begin
            x = (x[15] ^ d[i]) ? ((x << 1) ^ CRC_POLY) : (x << 1);
        end
        crc_byte = x;
    endfunction

    // ==========================================
    // Bus access decode
    logic acc_r;
    logic [1:0] ctrl_r;
    logic density_select_n;
    logic cmd_wr;
    logic stat_rd;
    logic buf_acc;
    assign density_select_n = ctrl_r[0];
    assign cmd_wr = avs_write && !acc_r && (avs_address == ADDR_CMD_STATUS);
    assign stat_rd = avs_read && !acc_r && (avs_address == ADDR_CMD_STATUS);
    assign buf_acc = (avs_read || avs_write) && !acc_r && (avs_address == ADDR_BYTE_BUF);

    // One wait cycle, answer on second edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= 1'b0;
        end else begin
            acc_r <= (avs_read || avs_write) && !acc_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !acc_r);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= 2'h0;
        end else if (avs_write && !acc_r && avs_address == ADDR_CTRL) begin
            ctrl_r <= avs_writedata[1:0];
        end
    end

    // ==========================================
    // Engine state
    eng_e state_r;
    logic [7:0] status_r;
    logic [7:0] buf_r;
    logic buf_full_r;
    logic started_r;
    logic [13:0] cell_cnt_r;
    logic [15:0] crc_r;
    logic crc_hi_r;
    logic idx_d_r;
    logic rdy_d_r;
    logic [3:0] cond_r;
    logic imm_hold_r;
    logic idx_rise;
    logic cell_end;
    logic force_cmd;
    logic wrtrk_cmd;
    assign idx_rise = index_pulse && !idx_d_r;
    assign cell_end = (cell_cnt_r == 14'h0000);
    assign force_cmd = cmd_wr && (avs_writedata[7:4] == CMD_TYPE_FORCE);
    assign wrtrk_cmd = cmd_wr && (avs_writedata[7:4] == CMD_TYPE_WRTRK);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_d_r <= 1'b0;
            rdy_d_r <= 1'b0;
        end else begin
            idx_d_r <= index_pulse;
            rdy_d_r <= drive_ready;
        end
    end

    // Command sequencing
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            head_load <= 1'b0;
            write_gate <= 1'b0;
        end else if (force_cmd) begin
            state_r <= ST_IDLE;
            write_gate <= 1'b0;
        end else if (wrtrk_cmd) begin
            state_r <= ST_WAIT_IDX;
            head_load <= 1'b1;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    write_gate <= 1'b0;
                end
                ST_WAIT_IDX: begin
                    if (idx_rise && buf_full_r) begin
                        state_r <= ST_WRITE;
                        write_gate <= 1'b1;
                    end else if (idx_rise) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_WRITE: begin
                    if (idx_rise) begin
                        state_r <= ST_IDLE;
                        write_gate <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Byte cell timer; restarts at track start
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cell_cnt_r <= 14'h0000;
        end else if (state_r != ST_WRITE || cell_end) begin
            cell_cnt_r <= density_select_n ? CELL_FM_CYC - 14'h0001 : CELL_MFM_CYC - 14'h0001;
        end else begin
            cell_cnt_r <= cell_cnt_r - 14'h0001;
        end
    end

    // Byte buffer: host load vs engine take
    logic take;
    assign take = (state_r == ST_WRITE) && cell_end && !crc_hi_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_r <= 8'h00;
            buf_full_r <= 1'b0;
        end else if (avs_write && !acc_r && avs_address == ADDR_BYTE_BUF) begin
            buf_r <= avs_writedata[7:0];
            buf_full_r <= 1'b1;
        end else if (take || wrtrk_cmd) begin
            buf_full_r <= 1'b0;
        end
    end

    // Serializer: one byte per cell with its clock pattern
    logic [7:0] cur;
    assign cur = buf_full_r ? buf_r : 8'h00;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_data <= 8'h00;
            wr_clock <= CLK_NORMAL;
            wr_strobe <= 1'b0;
            crc_r <= CRC_PRESET;
            crc_hi_r <= 1'b0;
        end else begin
            wr_strobe <= (state_r == ST_WRITE) && cell_end;
            if (state_r == ST_WRITE && cell_end) begin
                if (crc_hi_r) begin
                    wr_data <= crc_r[7:0];
                    wr_clock <= CLK_NORMAL;
                    crc_hi_r <= 1'b0;
                end else if (cur == CODE_CRC) begin
                    wr_data <= crc_r[15:8];
                    wr_clock <= CLK_NORMAL;
                    crc_hi_r <= 1'b1;
                end else if (density_select_n) begin
                    wr_data <= cur;
                    wr_clock <= fm_preset(cur) ? CLK_MARK_C7 :
                        (cur == CODE_FC) ? CLK_MARK_D7 : CLK_NORMAL;
                    crc_r <= fm_preset(cur) ? crc_byte(CRC_PRESET, cur) : crc_byte(crc_r, cur);
                end else if (cur == CODE_A1) begin
                    // A1 missing clock bit 2, preset
                    wr_data <= MFM_A1;
                    wr_clock <= 8'hFB;
                    crc_r <= crc_byte(CRC_PRESET, MFM_A1);
                end else if (cur == CODE_C2) begin
                    wr_data <= MFM_C2;
                    wr_clock <= 8'hF7;
                    crc_r <= crc_byte(crc_r, MFM_C2);
                end else begin
                    wr_data <= cur;
                    wr_clock <= CLK_NORMAL;
                    crc_r <= crc_byte(crc_r, cur);
                end
            end
        end
    end

    // ==========================================
    // Forced-interrupt conditions
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_r <= 4'h0;
        end else if (force_cmd) begin
            cond_r <= avs_writedata[3:0];
        end else if (cmd_wr) begin
            cond_r <= 4'h0;
        end
    end

    logic cond_hit;
    assign cond_hit = (cond_r[0] && drive_ready && !rdy_d_r) ||
        (cond_r[1] && !drive_ready && rdy_d_r) || (cond_r[2] && idx_rise);

    // Interrupt output
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            completion_irq <= 1'b0;
            imm_hold_r <= 1'b0;
        end else if (force_cmd && avs_writedata[3]) begin
            completion_irq <= 1'b1;
            imm_hold_r <= 1'b1;
        end else if (force_cmd && avs_writedata[3:0] == 4'h0) begin
            completion_irq <= 1'b0;
            imm_hold_r <= 1'b0;
        end else if (cond_hit || (state_r == ST_WAIT_IDX && idx_rise && !buf_full_r)
            || (state_r == ST_WRITE && idx_rise)) begin
            completion_irq <= 1'b1;
        end else if ((stat_rd || cmd_wr) && !imm_hold_r) begin
            completion_irq <= 1'b0;
        end
    end

    // ==========================================
    // Status and byte request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= STATUS_RESET;
            byte_request <= 1'b0;
        end else if (force_cmd) begin
            if (status_r[ST_BUSY]) begin
                status_r[ST_BUSY] <= 1'b0;
            end else begin
                status_r <= {!drive_ready, 5'h00, index_pulse, 1'b0};
            end
            byte_request <= 1'b0;
        end else if (wrtrk_cmd) begin
            // new command sets busy and byte request, clears rest
            status_r <= 8'h03;
            byte_request <= 1'b1;
        end else begin
            if (state_r == ST_WAIT_IDX && idx_rise && !buf_full_r) begin
                status_r[ST_BUSY] <= 1'b0;
                status_r[ST_LOST] <= 1'b1;
            end else if (state_r == ST_WRITE && idx_rise) begin
                status_r[ST_BUSY] <= 1'b0;
            end else if (take && !buf_full_r) begin
                status_r[ST_LOST] <= 1'b1;
            end
            // Request set wins over host clear; CRC tail cell asks for nothing
            if (take && !idx_rise) begin
                status_r[ST_BYTE_REQ] <= 1'b1;
                byte_request <= 1'b1;
            end else if (buf_acc || state_r == ST_IDLE) begin
                status_r[ST_BYTE_REQ] <= 1'b0;
                byte_request <= 1'b0;
            end
        end
    end

    // Read data, registered with the answer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !acc_r) begin
            case (avs_address)
                ADDR_CMD_STATUS: avs_readdata <= {24'h000000, status_r};
                ADDR_BYTE_BUF: avs_readdata <= {24'h000000, buf_r};
                ADDR_CTRL: avs_readdata <= {30'h00000000, ctrl_r};
                default: avs_readdata <= {24'h000000, wr_data};
            endcase
        end
    end

endmodule
`default_nettype wire

// file: sim/fmt_engine_props.sv
/* Checker on the fmt_engine ports.
   Assumes the bind below reaches every fmt_engine instance. */
`timescale 1ns/100ps
`default_nettype none
module fmt_engine_props
    import fmt_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Bus
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    // Drive and host lines
    input wire logic head_load,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] wr_clock,
    input wire logic wr_strobe,
    input wire logic byte_request,
    input wire logic completion_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic tk, cw, fi, hold_r;
    assign tk = (avs_read | avs_write) & avs_waitrequest;
    assign cw = tk & avs_write & (avs_address == ADDR_CMD_STATUS);
    assign fi = cw & (avs_writedata[7:4] == CMD_TYPE_FORCE);
    // ==========
    // hold until bare forced interrupt
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= 1'b0;
        end else if (fi && (avs_writedata[3] || avs_writedata[3:0] == 4'h0)) begin
            hold_r <= avs_writedata[3];
        end
    end
    property p_buf_clear;
        tk && avs_address == ADDR_BYTE_BUF |=> !byte_request || wr_strobe || $past(wr_strobe);
    endproperty
    a_buf_clear: assert property (p_buf_clear) else $error("byte request kept");
    property p_stat_clear;
        tk && avs_read && avs_address == ADDR_CMD_STATUS && !hold_r |=> !completion_irq;
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("irq kept");
    property p_hold;
        hold_r && $past(hold_r) |-> completion_irq;
    endproperty
    a_hold: assert property (p_hold) else $error("immediate irq lost");
    property p_quiet;
        fi && avs_writedata[3:0] == 4'h0 && !hold_r |=> !completion_irq [*4];
    endproperty
    a_quiet: assert property (p_quiet) else $error("irq on bare abort");
    property p_start;
        cw && avs_writedata[7:4] == CMD_TYPE_WRTRK |-> ##[1:2] (head_load && byte_request);
    endproperty
    a_start: assert property (p_start) else $error("track start late");
    property p_imm;
        fi && avs_writedata[3] |-> ##[1:3] completion_irq;
    endproperty
    a_imm: assert property (p_imm) else $error("no immediate irq");
    property p_fm_d7;
        wr_strobe && wr_clock == CLK_MARK_D7 |-> wr_data == CODE_FC;
    endproperty
    a_fm_d7: assert property (p_fm_d7) else $error("bad clock pattern");
    property p_mfm_a1;
        wr_strobe && wr_clock == 8'hFB |-> wr_data == MFM_A1;
    endproperty
    a_mfm_a1: assert property (p_mfm_a1) else $error("bad missing clock");
endmodule
bind fmt_engine fmt_engine_props u_fmt_engine_props (.sys_clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .head_load, .wr_data,
    .wr_clock, .wr_strobe, .byte_request, .completion_irq);
`default_nettype wire

// file: sim/drive_model.sv
/* Drive model: index pulse train and ready level.
   Assumes bench control changes on sys_clk edges. */
`timescale 1ns/100ps
`default_nettype none
module drive_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Bench control
    input wire logic spin,
    input wire logic [15:0] per,
    input wire logic rdy,
    // Drive lines
    output logic index_pulse,
    output logic drive_ready
);
    // ==========
    // Four-wide pulse at spin-up, then every per+1 cycles; none while stopped
    logic [15:0] cnt_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= (!spin || cnt_r == per) ? 16'h0000 : cnt_r + 16'h0001;
        end
    end
    assign index_pulse = spin && cnt_r < 16'h0004;
    assign drive_ready = rdy;
endmodule
`default_nettype wire

// file: sim/fmt_engine_tb_top.sv
/* Bench: bus tasks, byte cell model, verdict.
   Assumes fmt_pkg, drive_model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module fmt_engine_tb_top
    import fmt_pkg::*;
;
    logic sys_clk, rst_n, rd, wr, spin, rdy, idx, drdy, wreq, hl, wg, stb, breq, irq, fm;
    logic [1:0] adr;
    logic [31:0] wd, rdat, sts, lfsr;
    logic [7:0] wdat, wclk;
    logic [15:0] per, e, crc;
    logic [15:0] q[$];
    int src[$];
    int mismatches, samples_checked, cyc, x;
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    fmt_engine u_fmt_engine (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .index_pulse(idx), .drive_ready(drdy), .head_load(hl),
        .write_gate(wg), .wr_data(wdat), .wr_clock(wclk), .wr_strobe(stb),
        .byte_request(breq), .completion_irq(irq));
    drive_model u_drive_model (.sys_clk(sys_clk), .rst_n(rst_n), .spin(spin), .per(per),
        .rdy(rdy), .index_pulse(idx), .drive_ready(drdy));
    // ==========
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= {24'h000000, d};
        @(posedge sys_clk);
        while (wreq !== 1'b0) begin
            @(posedge sys_clk);
        end
        sts = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic cmd(input logic [7:0] v);
        bus(1'b1, ADDR_CMD_STATUS, v);
        repeat (fm ? 7000 : 3500) @(posedge sys_clk);
    endtask
    function automatic logic [15:0] model(input logic [7:0] b, input logic f);
        if (f && b == CODE_FC) begin
            return {CLK_MARK_D7, b};
        end else if (f && (b inside {[CODE_F8:8'hFB], CODE_HI})) begin
            return {CLK_MARK_C7, b};
        end else if (!f && b == CODE_A1) begin
            return {8'hFB, MFM_A1};
        end else if (!f && b == CODE_C2) begin
            return {8'hF7, MFM_C2};
        end
        return {CLK_NORMAL, b};
    endfunction
    function automatic logic [15:0] crc_model(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[7 - i]) ? CRC_POLY : 16'h0000);
        end
        return r;
    endfunction
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // one byte per request, none for a negative entry; marks only as codes
    task automatic load(input int v, input logic f);
        logic [15:0] m;
        m = model(8'(v), f);
        if (v < 0) begin
            crc = crc_model(crc, 8'h00);
        end else begin
            bus(1'b1, ADDR_BYTE_BUF, 8'(v));
            check(16'(breq), 16'h0000);
            if (8'(v) == CODE_CRC) begin
                q.push_back({CLK_NORMAL, crc[15:8]});
                q.push_back({CLK_NORMAL, crc[7:0]});
            end else begin
                q.push_back(m);
                crc = crc_model((f ? (m[15:8] == CLK_MARK_C7) : (8'(v) == CODE_A1)) ?
                    CRC_PRESET : crc, m[7:0]);
            end
        end
    endtask
    task automatic track(input logic f, input logic [15:0] p);
        fm = f;
        crc = CRC_PRESET;
        bus(1'b1, ADDR_CTRL, {7'h00, f});
        cmd(8'hF0);
        bus(1'b0, ADDR_CMD_STATUS, 8'h00);
        check(16'(sts[1:0]), 16'h0003);
        load(src.pop_front(), f);
        per <= p;
        spin <= 1'b1;
        while (src.size() > 0) begin
            while (stb !== 1'b1) @(posedge sys_clk);
            @(posedge sys_clk);
            load(src.pop_front(), f);
        end
        while (irq !== 1'b1) @(posedge sys_clk);
        spin <= 1'b0;
        bus(1'b0, ADDR_CMD_STATUS, 8'h00);
        check({14'h0000, wg, sts[ST_BUSY]}, 16'h0000);
        check(16'(q.size()), 16'h0000);
    endtask
    // Cell model compared at every strobe; timeout ends the run
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (stb === 1'b1) begin
            e = (q.size() > 0) ? q.pop_front() : {CLK_NORMAL, 8'h00};
            check({wclk, wdat}, e);
        end
        if (cyc == 100000) begin
            mismatches++;
            print_verdict();
        end
    end
    // ==========
    // Main sequence
    initial begin
        {rst_n, rd, wr, spin, fm, adr, wd, per, mismatches, samples_checked, cyc} = '0;
        rdy = 1'b1;
        lfsr = 32'h43342014;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        bus(1'b1, ADDR_CTRL, 8'h00);
        cmd(8'hF0);
        bus(1'b0, ADDR_CMD_STATUS, 8'h00);
        check({13'h0000, hl, breq, sts[ST_BUSY]}, 16'h0007);
        per <= 16'h00C8;
        spin <= 1'b1;
        while (irq !== 1'b1) @(posedge sys_clk);
        spin <= 1'b0;
        bus(1'b0, ADDR_CMD_STATUS, 8'h00);
        check({sts[7:0] & 8'h05, 7'h00, irq}, 16'h0400);
        cmd(8'hF0);
        cmd(8'hD0);
        bus(1'b0, ADDR_CMD_STATUS, 8'h00);
        check({13'h0000, wg, irq, sts[ST_BUSY]}, 16'h0000);
        rdy <= 1'b0;
        cmd(8'hD0);
        bus(1'b0, ADDR_CMD_STATUS, 8'h00);
        check({14'h0000, sts[ST_READY_N], sts[ST_INDEX]}, 16'h0002);
        rdy <= 1'b1;
        cmd(8'hD8);
        bus(1'b0, ADDR_CMD_STATUS, 8'h00);
        check(16'(irq), 16'h0001);
        cmd(8'hD0);
        bus(1'b0, ADDR_CMD_STATUS, 8'h00);
        check(16'(irq), 16'h0000);
        for (int i = 0; i < 3; i++) begin
            rdy <= (i != 0);
            cmd(8'hD0 | (8'h01 << i));
            check(16'(irq), 16'h0000);
            per <= 16'h0064;
            spin <= (i == 2);
            if (i != 2) rdy <= (i == 0);
            x = 0;
            while (irq !== 1'b1 && x < 300) begin
                @(posedge sys_clk);
                x++;
            end
            spin <= 1'b0;
            check(16'(irq), 16'h0001);
            bus(1'b0, ADDR_CMD_STATUS, 8'h00);
            check(16'(irq), 16'h0000);
        end
        lfsr = lfsr_next(lfsr);
        src = '{8'hF5, 8'hF6, -1, int'(lfsr[7:0]) % 245, 8'hF7};
        track(1'b0, 16'h5FB4);
        src = '{8'hFE, 8'hFC};
        track(1'b1, 16'h4268);
        print_verdict();
    end
endmodule
`default_nettype wire
